// >>> design/iemd_decoder.sv
`timescale 1ns/1ps
module iemd_decoder #(
	parameter int MARKS_W = iemd_pkg::MARKS_W,
	parameter int CNT_W   = 32
) (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// configuration
	input  wire logic [iemd_pkg::MODE_W-1:0] mode,
	input  wire logic [iemd_pkg::CFG_W-1:0]  drive_config,
	input  wire logic [MARKS_W-1:0]          division_marks,
	// sensor pins
	input  wire iemd_pkg::iemd_tracks_s      tracks,
	// results
	output logic                             count_pulse,
	output logic                             count_negative,
	output logic signed [CNT_W-1:0]          position_ff,
	output logic                             direction_cw_ff,
	output logic                             ref_seen_ff,
	output logic                             ref_error_ff,
	output logic                             measure_active,
	output logic                             second_input_is_track_b,
	output logic                             second_input_free
);

	// ****************************************
	// mode decode
	// ****************************************
	iemd_pkg::iemd_mode_s md;

	always_comb begin
		md = '{src: iemd_pkg::IEMD_SRC_OFF, edges: 3'h0, invert: 1'b0,
			use_ref: 1'b0, use_b: 1'b0};
		case (mode)
			iemd_pkg::MODE_1, iemd_pkg::MODE_101, iemd_pkg::MODE_1001,
			iemd_pkg::MODE_1101: begin // [R16] [R5] [R7] [R10]
				md.src   = iemd_pkg::IEMD_SRC_QUAD;
				md.edges = 3'h1;
			end
			iemd_pkg::MODE_1002, iemd_pkg::MODE_1102: begin // [R7] [R10]
				md.src   = iemd_pkg::IEMD_SRC_QUAD;
				md.edges = 3'h2;
			end
			iemd_pkg::MODE_4, iemd_pkg::MODE_104, iemd_pkg::MODE_1004,
			iemd_pkg::MODE_1104: begin // [R16] [R5] [R7] [R10]
				md.src   = iemd_pkg::IEMD_SRC_QUAD;
				md.edges = 3'h4;
			end
			iemd_pkg::MODE_11, iemd_pkg::MODE_1011: begin // [R1] [R8]
				md.src   = iemd_pkg::IEMD_SRC_POS;
				md.edges = 3'h1;
			end
			iemd_pkg::MODE_12, iemd_pkg::MODE_1012: begin // [R2] [R8]
				md.src   = iemd_pkg::IEMD_SRC_POS;
				md.edges = 3'h2;
			end
			iemd_pkg::MODE_111, iemd_pkg::MODE_1111: begin // [R6] [R11]
				md.src   = iemd_pkg::IEMD_SRC_NEG;
				md.edges = 3'h1;
			end
			iemd_pkg::MODE_112, iemd_pkg::MODE_1112: begin // [R6] [R11]
				md.src   = iemd_pkg::IEMD_SRC_NEG;
				md.edges = 3'h2;
			end
			iemd_pkg::MODE_31, iemd_pkg::MODE_1031: begin // [R3] [R9]
				md.src   = iemd_pkg::IEMD_SRC_DIR;
				md.edges = 3'h1;
			end
			iemd_pkg::MODE_32, iemd_pkg::MODE_1032: begin // [R3] [R9]
				md.src   = iemd_pkg::IEMD_SRC_DIR;
				md.edges = 3'h2;
			end
			iemd_pkg::MODE_131, iemd_pkg::MODE_1131: begin // [R4] [R12]
				md.src   = iemd_pkg::IEMD_SRC_DIR_INV;
				md.edges = 3'h1;
			end
			iemd_pkg::MODE_132, iemd_pkg::MODE_1132: begin // [R4] [R12]
				md.src   = iemd_pkg::IEMD_SRC_DIR_INV;
				md.edges = 3'h2;
			end
			default: begin
				md.src = iemd_pkg::IEMD_SRC_OFF; // [R16] [R19]
			end
		endcase
		md.invert  = (mode == iemd_pkg::MODE_101) || (mode == iemd_pkg::MODE_104)
			|| (mode >= iemd_pkg::MODE_1101 && mode <= iemd_pkg::MODE_1104); // [R5] [R10]
		md.use_ref = (md.src != iemd_pkg::IEMD_SRC_OFF)
			&& (mode >= iemd_pkg::MODE_1001); // [R7] [R8] [R9] [R12]
		// single-track unsigned modes never read the second input
		md.use_b   = (md.src == iemd_pkg::IEMD_SRC_QUAD)
			|| (md.src == iemd_pkg::IEMD_SRC_DIR)
			|| (md.src == iemd_pkg::IEMD_SRC_DIR_INV); // [R13] [R15]
	end

	assign measure_active    = (md.src != iemd_pkg::IEMD_SRC_OFF); // [R19]
	assign second_input_free = !md.use_b; // [R13] [R15]
	assign second_input_is_track_b = md.use_b
		&& ((drive_config == iemd_pkg::CFG_210) || (drive_config == iemd_pkg::CFG_211)
		|| (drive_config == iemd_pkg::CFG_230)); // [R14]

	// ****************************************
	// input synchronisers
	// ****************************************
	iemd_pkg::iemd_tracks_s sync1_ff;
	iemd_pkg::iemd_tracks_s sync2_ff;
	iemd_pkg::iemd_tracks_s prev_ff;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			prev_ff  <= '0;
		end else begin
			sync1_ff <= tracks; // [R20]
			sync2_ff <= sync1_ff; // [R20]
			prev_ff  <= sync2_ff;
		end
	end

	logic a_rise, a_fall, b_rise, b_fall, z_rise;
	assign a_rise = sync2_ff.track_a && !prev_ff.track_a;
	assign a_fall = !sync2_ff.track_a && prev_ff.track_a;
	assign b_rise = sync2_ff.track_b && !prev_ff.track_b;
	assign b_fall = !sync2_ff.track_b && prev_ff.track_b;
	assign z_rise = sync2_ff.ref_pulse && !prev_ff.ref_pulse;

	// ****************************************
	// edge selection and sign
	// ****************************************
	logic quad_cw, quad_ccw, quad_edge, raw_neg;

	// gray sequence 00-10-11-01 (a,b) is clockwise: A rises, then B rises
	always_comb begin
		quad_cw  = (a_rise && !sync2_ff.track_b) || (b_rise && sync2_ff.track_a)
			|| (a_fall && sync2_ff.track_b) || (b_fall && !sync2_ff.track_a); // [R17]
		quad_ccw = (a_rise && sync2_ff.track_b) || (b_fall && sync2_ff.track_a)
			|| (a_fall && !sync2_ff.track_b) || (b_rise && !sync2_ff.track_a); // [R17]
		case (md.edges)
			3'h1:    quad_edge = a_rise && !sync2_ff.track_b || a_fall && !sync2_ff.track_b;
			3'h2:    quad_edge = a_rise || a_fall;
			3'h4:    quad_edge = quad_cw || quad_ccw;
			default: quad_edge = 1'b0;
		endcase
	end

	// double-edge quadrature counts both A edges per mark, direction from B level
	logic quad_single_neg;
	assign quad_single_neg = (a_rise && sync2_ff.track_b) || (a_fall && !sync2_ff.track_b);

	always_comb begin
		count_pulse = 1'b0;
		raw_neg     = 1'b0;
		case (md.src)
			iemd_pkg::IEMD_SRC_QUAD: begin
				if (md.edges == 3'h1) begin
					count_pulse = a_rise; // [R16] [R7]
					raw_neg     = sync2_ff.track_b;
				end else if (md.edges == 3'h2) begin
					count_pulse = a_rise || a_fall; // [R7]
					raw_neg     = quad_single_neg;
				end else begin
					count_pulse = quad_edge; // [R16] [R7]
					raw_neg     = quad_ccw;
				end
			end
			iemd_pkg::IEMD_SRC_POS: begin
				count_pulse = (md.edges == 3'h1) ? a_rise : (a_rise || a_fall); // [R1] [R2]
				raw_neg     = 1'b0;
			end
			iemd_pkg::IEMD_SRC_NEG: begin
				count_pulse = (md.edges == 3'h1) ? a_rise : (a_rise || a_fall); // [R6]
				raw_neg     = 1'b1;
			end
			iemd_pkg::IEMD_SRC_DIR: begin
				count_pulse = (md.edges == 3'h1) ? a_rise : (a_rise || a_fall); // [R3]
				raw_neg     = sync2_ff.track_b; // [R3]
			end
			iemd_pkg::IEMD_SRC_DIR_INV: begin
				count_pulse = (md.edges == 3'h1) ? a_rise : (a_rise || a_fall); // [R4]
				raw_neg     = !sync2_ff.track_b; // [R4]
			end
			default: begin
				count_pulse = 1'b0;
				raw_neg     = 1'b0;
			end
		endcase
		count_negative = count_pulse && (raw_neg ^ md.invert); // [R5] [R10]
	end

	// ****************************************
	// position and direction
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			position_ff     <= '0;
			direction_cw_ff <= 1'b1;
		end else if (count_pulse) begin
			position_ff     <= count_negative ? position_ff - CNT_W'(1)
				: position_ff + CNT_W'(1);
			direction_cw_ff <= !count_negative;
		end
	end

	// ****************************************
	// reference plausibility
	// ****************************************
	// counts A rising edges between reference pulses, so the check is
	// independent of the evaluation multiple; direction is not considered
	logic [MARKS_W-1:0] marks_ff;

	always_ff @(posedge mclk) begin
		if (!resetn || !md.use_ref) begin
			marks_ff     <= '0;
			ref_seen_ff  <= 1'b0;
			ref_error_ff <= 1'b0;
		end else if (z_rise) begin
			marks_ff    <= '0;
			ref_seen_ff <= 1'b1;
			if (ref_seen_ff && (marks_ff != division_marks))
				ref_error_ff <= 1'b1; // [R18]
		end else if (a_rise) begin
			if (ref_seen_ff && (marks_ff >= division_marks))
				ref_error_ff <= 1'b1; // [R18]
			else
				marks_ff <= marks_ff + MARKS_W'(1);
		end
	end

endmodule : iemd_decoder

// >>> design/iemd_pkg.sv
// Operation
// [R1] mode 11: A single edge, speed positive
// [R2] mode 12: A both edges, speed positive
// [R3] 31/32: A only, direction low positive
// [R4] 131/132: direction low negative, high positive
// [R5] 101/104: as 1/4, sign inverted
// [R6] 111/112: as 11/12, speed negative
// [R7] 1001/1002/1004: quadrature plus reference pulse
// [R8] 1011/1012: as 11/12 plus reference pulse
// [R9] 1031/1032: as 31/32 plus reference pulse
// [R10] 1101/1102/1104: as 100x, speed negative
// [R11] 1111/1112: as 1011/1012, speed negative
// [R12] 1131/1132: as 131/132 plus reference pulse
// [R13] 1011/1012 leave second input free
// [R14] configs 210/211/230 default second input track B
// [R15] modes 11/12 release second input
// [R16] mode 0 off; 1 and 4 quadrature
// [R17] A rise then B rise is clockwise
// [R18] check one reference pulse per mark count
// [R19] unknown mode acts as mode 0
// [R20] two-stage sync on all track inputs
package iemd_pkg;

	localparam int MODE_W = 11;
	localparam int CFG_W  = 9;

	// **********************************************
	// mode codes
	// **********************************************
	localparam logic [MODE_W-1:0] MODE_OFF  = 11'd0;
	localparam logic [MODE_W-1:0] MODE_1    = 11'd1;
	localparam logic [MODE_W-1:0] MODE_4    = 11'd4;
	localparam logic [MODE_W-1:0] MODE_11   = 11'd11;
	localparam logic [MODE_W-1:0] MODE_12   = 11'd12;
	localparam logic [MODE_W-1:0] MODE_31   = 11'd31;
	localparam logic [MODE_W-1:0] MODE_32   = 11'd32;
	localparam logic [MODE_W-1:0] MODE_101  = 11'd101;
	localparam logic [MODE_W-1:0] MODE_104  = 11'd104;
	localparam logic [MODE_W-1:0] MODE_111  = 11'd111;
	localparam logic [MODE_W-1:0] MODE_112  = 11'd112;
	localparam logic [MODE_W-1:0] MODE_131  = 11'd131;
	localparam logic [MODE_W-1:0] MODE_132  = 11'd132;
	localparam logic [MODE_W-1:0] MODE_1001 = 11'd1001;
	localparam logic [MODE_W-1:0] MODE_1002 = 11'd1002;
	localparam logic [MODE_W-1:0] MODE_1004 = 11'd1004;
	localparam logic [MODE_W-1:0] MODE_1011 = 11'd1011;
	localparam logic [MODE_W-1:0] MODE_1012 = 11'd1012;
	localparam logic [MODE_W-1:0] MODE_1031 = 11'd1031;
	localparam logic [MODE_W-1:0] MODE_1032 = 11'd1032;
	localparam logic [MODE_W-1:0] MODE_1101 = 11'd1101;
	localparam logic [MODE_W-1:0] MODE_1102 = 11'd1102;
	localparam logic [MODE_W-1:0] MODE_1104 = 11'd1104;
	localparam logic [MODE_W-1:0] MODE_1111 = 11'd1111;
	localparam logic [MODE_W-1:0] MODE_1112 = 11'd1112;
	localparam logic [MODE_W-1:0] MODE_1131 = 11'd1131;
	localparam logic [MODE_W-1:0] MODE_1132 = 11'd1132;

	// drive configurations that route the second input to track B
	localparam logic [CFG_W-1:0] CFG_210 = 9'd210;
	localparam logic [CFG_W-1:0] CFG_211 = 9'd211;
	localparam logic [CFG_W-1:0] CFG_230 = 9'd230;

	localparam int MARKS_W       = 14;
	localparam int MARKS_DEFAULT = 1024;

	// **********************************************
	// decoded mode
	// **********************************************
	typedef enum logic [2:0] {
		IEMD_SRC_OFF,
		IEMD_SRC_QUAD,
		IEMD_SRC_POS,
		IEMD_SRC_NEG,
		IEMD_SRC_DIR,
		IEMD_SRC_DIR_INV
	} iemd_src_e;

	typedef struct packed {
		iemd_src_e  src;
		logic [2:0] edges;
		logic       invert;
		logic       use_ref;
		logic       use_b;
	} iemd_mode_s;

	typedef struct packed {
		logic track_a;
		logic track_b;
		logic ref_pulse;
	} iemd_tracks_s;

endpackage : iemd_pkg

// >>> sim/iemd_decoder_properties.sv
`timescale 1ns/1ps
module iemd_decoder_properties #(
	parameter int MARKS_W	= 14,
	parameter int CNT_W	= 32
) (
	// clock and reset
	input wire logic				mclk,
	input wire logic				resetn,
	// configuration
	input wire logic [iemd_pkg::MODE_W-1:0]	mode,
	input wire logic [iemd_pkg::CFG_W-1:0]	drive_config,
	input wire logic [MARKS_W-1:0]		division_marks,
	input wire iemd_pkg::iemd_tracks_s		tracks,
	// results
	input wire logic				count_pulse,
	input wire logic				count_negative,
	input wire logic signed [CNT_W-1:0]		position_ff,
	input wire logic				direction_cw_ff,
	input wire logic				ref_seen_ff,
	input wire logic				ref_error_ff,
	input wire logic				measure_active,
	input wire logic				second_input_is_track_b,
	input wire logic				second_input_free
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// ********
	// counting and sign
	// ********
	// pin level sampled at edge n reaches stage 2 at n+1, so the pulse is seen at n+2
	single_rise_a:
		assert property (mode == 11'h00b && $rose(tracks.track_a) |-> ##2 count_pulse
			&& !count_negative) else $error("mode 11 rise miscounted");
	double_fall_a:
		assert property (mode == 11'h00c && $fell(tracks.track_a) |-> ##2 count_pulse
			&& !count_negative) else $error("mode 12 fall miscounted");
	dir_contact_a:
		assert property (count_pulse && mode inside {11'h01f, 11'h020}
			|-> count_negative == $past(tracks.track_b, 2)) else $error("contact sign");
	dir_inverse_a:
		assert property (count_pulse && mode inside {11'h083, 11'h084}
			|-> count_negative != $past(tracks.track_b, 2)) else $error("inverse sign");
	neg_only_a:
		assert property (count_pulse && mode inside {11'h06f, 11'h070} |-> count_negative)
		else $error("negative mode sign");
	quad_b_a:
		assert property (mode == 11'h004 && $rose(tracks.track_b) |-> ##2 count_pulse)
		else $error("quad b edge missed");
	sync_delay_a:
		assert property (measure_active && $rose(tracks.track_a)
			|-> ##1 !count_pulse ##1 count_pulse) else $error("sync latency wrong");
	off_quiet_a:
		assert property ((!measure_active) [*4] |-> !count_pulse) else $error("count when off");
	off_map_a:
		assert property (mode == 11'h000 |-> !measure_active && second_input_free)
		else $error("mode 0 active");
	free_b_a:
		assert property (mode inside {11'h00b, 11'h00c} |-> second_input_free
			&& !second_input_is_track_b) else $error("second input held");
	track_b_a:
		assert property (mode == 11'h001 && drive_config inside {9'h0d2, 9'h0d3, 9'h0e6}
			|-> second_input_is_track_b) else $error("track b not routed");
endmodule : iemd_decoder_properties

bind iemd_decoder iemd_decoder_properties #(.MARKS_W(MARKS_W), .CNT_W(CNT_W)) i_props (
	.mclk, .resetn, .mode, .drive_config, .division_marks, .tracks, .count_pulse,
	.count_negative, .position_ff, .direction_cw_ff, .ref_seen_ff, .ref_error_ff,
	.measure_active, .second_input_is_track_b, .second_input_free);

// >>> sim/iemd_encoder_model.sv
`timescale 1ns/1ps
module iemd_encoder_model (
	// clock
	input wire logic		mclk,
	// motion
	input wire logic		step,
	input wire logic		cw,
	input wire logic		quad,
	input wire logic		dir_b,
	input wire logic		zref,
	// sensor pins
	output iemd_pkg::iemd_tracks_s	tracks
);
	// gray order: a leads b when turning clockwise
	logic [1:0]	phase_ff = 2'h0;

	always_ff @(posedge mclk) begin
		if (step) begin
			phase_ff <= cw ? phase_ff + 2'h1 : phase_ff - 2'h1;
		end
	end

	// push-pull drivers; in single-track use b is a held contact level
	assign tracks = '{track_a: (quad ? ^phase_ff : phase_ff[0]),
		track_b: (quad ? phase_ff[1] : dir_b), ref_pulse: zref};
endmodule : iemd_encoder_model

// >>> sim/incremental_encoder_mode_decoder_tb.sv
`timescale 1ns/1ps
module incremental_encoder_mode_decoder_tb;
	logic					mclk, resetn, step, cw, quad, dir_b, zref;
	logic					count_pulse, count_negative, direction_cw_ff;
	logic					ref_seen_ff, ref_error_ff, measure_active;
	logic					second_input_is_track_b, second_input_free;
	logic [iemd_pkg::MODE_W-1:0]		mode;
	logic [iemd_pkg::CFG_W-1:0]		drive_config;
	logic [iemd_pkg::MARKS_W-1:0]	division_marks;
	logic signed [31:0]			position_ff;
	iemd_pkg::iemd_tracks_s		tracks;
	int					num_errors, samples_checked;

	iemd_decoder #(.CNT_W(32)) i_dut (.mclk, .resetn, .mode, .drive_config, .division_marks,
		.tracks, .count_pulse, .count_negative, .position_ff, .direction_cw_ff, .ref_seen_ff,
		.ref_error_ff, .measure_active, .second_input_is_track_b, .second_input_free);
	iemd_encoder_model i_enc (.mclk, .step, .cw, .quad, .dir_b, .zref, .tracks);

	// ********
	// helpers
	// ********
	task automatic chk(input logic [31:0] g, e, input string s);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t %s got %0h exp %0h", $time, s, g, e);
		end
	endtask : chk

	// pins change first, mode later, so no edge is in flight at the switch
	task automatic setm(input logic [10:0] m, input bit q, d);
		@(posedge mclk);
		quad <= q;
		dir_b <= d;
		repeat (8) @(posedge mclk);
		mode <= m;
		repeat (8) @(posedge mclk);
		#1;
	endtask : setm

	// whole marks only, so the phase is back at zero between calls
	task automatic marks(input int n, input bit c);
		for (int i = 0; i < n * (quad ? 4 : 2); i++) begin
			@(posedge mclk);
			step <= 1'b1;
			cw <= quad ? c : (i % 2 == 0);
			@(posedge mclk);
			step <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		repeat (8) @(posedge mclk);
		#1;
	endtask : marks

	task automatic zpulse;
		@(posedge mclk);
		zref <= 1'b1;
		repeat (2) @(posedge mclk);
		zref <= 1'b0;
		repeat (8) @(posedge mclk);
		#1;
	endtask : zpulse

	// ********
	// scenarios
	// ********
	task automatic one(input logic [10:0] m, input bit q, d, c, input int e);
		logic signed [31:0] p0;
		setm(m, q, d);
		p0 = position_ff;
		marks(3, c);
		chk(position_ff - p0, 3 * e, "count");
		chk(measure_active, e != 0, "active");
		if (e != 0) begin
			chk(direction_cw_ff, e > 0, "sign");
		end
		$display("mode %0d done", m);
	endtask : one

	task automatic t_cfg;
		logic [8:0] cf [4] = '{9'h064, 9'h0d2, 9'h0d3, 9'h0e6};
		setm(11'h001, 1, 0);
		foreach (cf[i]) begin
			@(posedge mclk);
			drive_config <= cf[i];
			@(posedge mclk);
			#1;
			chk(second_input_is_track_b, i > 0, "track b");
		end
		setm(11'h00b, 0, 0);
		chk(second_input_free, 1'b1, "free");
		chk(second_input_is_track_b, 1'b0, "not b");
		setm(11'h3f3, 0, 0);
		chk(second_input_free, 1'b1, "ref free");
		$display("config test done");
	endtask : t_cfg

	task automatic t_ref;
		setm(11'h000, 1, 0);
		@(posedge mclk);
		division_marks <= 14'h0004;
		setm(11'h3ec, 1, 0);
		zpulse;
		marks(4, 1);
		zpulse;
		chk(ref_seen_ff, 1'b1, "ref seen");
		chk(ref_error_ff, 1'b0, "ref ok");
		marks(3, 1);
		zpulse;
		chk(ref_error_ff, 1'b1, "ref error");
		// leaving the reference mode clears the sticky flag
		setm(11'h000, 1, 0);
		chk(ref_error_ff, 1'b0, "ref clear");
		setm(11'h3ec, 1, 0);
		zpulse;
		marks(5, 1);
		chk(ref_error_ff, 1'b1, "ref overrun");
		$display("reference test done");
	endtask : t_ref

	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		resetn = 1'b0;
		mode = '0;
		drive_config = '0;
		division_marks = 14'h2000;
		{step, cw, quad, dir_b, zref} = 5'h04;
		num_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		one(11'h00b, 0, 1, 1, 1);
		one(11'h00c, 0, 1, 1, 2);
		one(11'h01f, 0, 0, 1, 1);
		one(11'h020, 0, 1, 1, -2);
		one(11'h083, 0, 0, 1, -1);
		one(11'h084, 0, 1, 1, 2);
		one(11'h001, 1, 0, 1, 1);
		one(11'h001, 1, 0, 0, -1);
		one(11'h004, 1, 0, 0, -4);
		one(11'h004, 1, 0, 1, 4);
		one(11'h065, 1, 0, 1, -1);
		one(11'h068, 1, 0, 1, -4);
		one(11'h06f, 0, 0, 1, -1);
		one(11'h070, 0, 1, 1, -2);
		one(11'h3e9, 1, 0, 0, -1);
		one(11'h3ea, 1, 0, 1, 2);
		one(11'h3ec, 1, 0, 1, 4);
		one(11'h3f3, 0, 1, 1, 1);
		one(11'h3f4, 0, 0, 1, 2);
		one(11'h407, 0, 1, 1, -1);
		one(11'h408, 0, 0, 1, 2);
		one(11'h44d, 1, 0, 1, -1);
		one(11'h44e, 1, 0, 0, 2);
		one(11'h450, 1, 0, 0, 4);
		one(11'h457, 0, 1, 1, -1);
		one(11'h458, 0, 0, 1, -2);
		one(11'h46b, 0, 1, 1, 1);
		one(11'h46c, 0, 0, 1, -2);
		one(11'h007, 1, 0, 1, 0);
		one(11'h000, 1, 0, 1, 0);
		t_cfg;
		t_ref;
		print_verdict;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		print_verdict;
	end
endmodule : incremental_encoder_mode_decoder_tb
